/* ipsel_regs.vh */
`ifndef IPSEL_REGS_VH
`define IPSEL_REGS_VH
`define IPSEL_ADDR 8'hB8
`define IPSEL_PAGE 8'h00
`define IPSEL_RESET 8'h80
`define IPSEL_WMASK 8'h7F
`define IPSEL_RD_IDLE 8'h00
`define IPSEL_NO_BITS 7'h00
`define IPSEL_ONE_BIT 7'h01
`define IPSEL_BIT_UNUSED 3'h7
`define IPSEL_BIT_SPI 3'h6
`define IPSEL_BIT_T2 3'h5
`define IPSEL_BIT_UART 3'h4
`define IPSEL_BIT_T1 3'h3
`define IPSEL_BIT_EX1 3'h2
`define IPSEL_BIT_T0 3'h1
`define IPSEL_BIT_EX0 3'h0
`define IPSEL_NSRC 4'h7
`endif

/* ipsel_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "ipsel_regs.vh"
module ipsel_top (
   // clock and reset
   input wire sys_clk_i,
   input wire resetn_i,
   // special-function register access from the core
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_page_i,
   input wire sfr_wr_i,
   input wire [7:0] sfr_wdata_i,
   input wire sfr_bit_wr_i,
   input wire [2:0] sfr_bit_sel_i,
   input wire sfr_bit_val_i,
   output wire [7:0] sfr_rdata_o,
   output wire sfr_hit_o,
   // sources: pending flags and enables, bit order as the priority register
   input wire [6:0] src_pending_i,
   input wire [6:0] src_enable_i,
   input wire global_enable_i,
   // service state from the sequencer
   input wire in_low_service_i,
   input wire in_high_service_i,
   // per-source level and gated requests
   output wire [6:0] src_priority_o,
   output wire [6:0] high_req_o,
   output wire [6:0] low_req_o,
   output wire irq_take_o,
   output wire irq_high_o
);

   // stored levels; bit 7 has no flip-flop and reads as a fixed one
   reg [6:0] prio_q;
   reg [6:0] prio_d;

   // access decode
   wire sel;

   // write strobes, already qualified by the decode
   wire wr_byte;
   wire wr_bit;

   // single-bit write helpers
   wire [6:0] bit_mask;
   wire [6:0] bit_fill;

   // enable masking of the pending flags
   wire [6:0] enable_mask;
   wire [6:0] active;

   // requests split by level
   wire [6:0] high_req;
   wire [6:0] low_req;
   wire any_high;
   wire any_low;

   // nesting decision
   wire can_high;
   wire can_low;
   wire take_high;
   wire take_low;

   // per-source levels, named after the sources they steer
   wire serial_port_priority;
   wire timer2_priority;
   wire uart_priority;
   wire timer1_priority;
   wire ext_irq1_priority;
   wire timer0_priority;
   wire ext_irq0_priority;

   // register image constants
   localparam [7:0] RESET_IMAGE = `IPSEL_RESET;
   localparam [7:0] WRITE_MASK = `IPSEL_WMASK;
   localparam [7:0] READ_IDLE = `IPSEL_RD_IDLE;

   // storage view of the image; bit 7 is dropped on purpose
   localparam [6:0] PRIO_RESET = RESET_IMAGE[6:0];
   localparam [6:0] PRIO_WMASK = WRITE_MASK[6:0];
   localparam [0:0] UNUSED_READ = RESET_IMAGE[`IPSEL_BIT_UNUSED];

   // level selectors for the split;
   // one function serves both levels so they cannot drift apart
   localparam [0:0] LEVEL_HIGH = 1'h1;
   localparam [0:0] LEVEL_LOW = 1'h0;

   // access names this register on its own page;
   // other pages reuse the address, so the page must match too
   function ipsel_hit;
      input [7:0] addr;
      input [7:0] page;
      begin
         ipsel_hit = (addr == `IPSEL_ADDR) && (page == `IPSEL_PAGE);
      end
   endfunction

   // one-hot mask for a bit write; the unused bit maps to none,
   // which is how writes to it are dropped
   function [6:0] ipsel_bit_mask;
      input [2:0] bit_sel;
      begin
         if (bit_sel == `IPSEL_BIT_UNUSED) begin
            ipsel_bit_mask = `IPSEL_NO_BITS;
         end else begin
            ipsel_bit_mask = `IPSEL_ONE_BIT << bit_sel;
         end
      end
   endfunction

   // requests of one level: active sources at the asked level
   function [6:0] ipsel_level_req;
      input [6:0] act;
      input [6:0] prio;
      input want_high;
      begin
         if (want_high) begin
            ipsel_level_req = act & prio;
         end else begin
            ipsel_level_req = act & ~prio;
         end
      end
   endfunction

   // any request present in a level vector
   function ipsel_any;
      input [6:0] req;
      begin
         ipsel_any = |req;
      end
   endfunction

   // access decode
   assign sel = ipsel_hit(sfr_addr_i, sfr_page_i);

   // write strobes
   assign wr_byte = sel && sfr_wr_i;
   assign wr_bit = sel && sfr_bit_wr_i;

   // bit write operands
   assign bit_mask = ipsel_bit_mask(sfr_bit_sel_i);
   assign bit_fill = {`IPSEL_NSRC{sfr_bit_val_i}};

   // next value; a byte write wins over a bit write in one cycle
   always @* begin
      prio_d = prio_q;
      if (wr_byte) begin
         prio_d = sfr_wdata_i[6:0] & PRIO_WMASK;
      end else if (wr_bit) begin
         prio_d = (prio_q & ~bit_mask) | (bit_fill & bit_mask);
      end
   end

   // synchronous reset puts every source at the low level
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         prio_q <= PRIO_RESET;
      end else begin
         prio_q <= prio_d;
      end
   end

   // select flag for the core's read mux
   assign sfr_hit_o = sel;

   // combinational read, same cycle as the address;
   // idle zero keeps a wired-or read bus quiet
   assign sfr_rdata_o = sel ? {UNUSED_READ, prio_q} : READ_IDLE;

   // per-source level taps, positions as in the register
   assign serial_port_priority = prio_q[`IPSEL_BIT_SPI];
   assign timer2_priority = prio_q[`IPSEL_BIT_T2];
   assign uart_priority = prio_q[`IPSEL_BIT_UART];
   assign timer1_priority = prio_q[`IPSEL_BIT_T1];
   assign ext_irq1_priority = prio_q[`IPSEL_BIT_EX1];
   assign timer0_priority = prio_q[`IPSEL_BIT_T0];
   assign ext_irq0_priority = prio_q[`IPSEL_BIT_EX0];

   // level bus to the sequencer, highest bit first
   assign src_priority_o = {
      serial_port_priority,
      timer2_priority,
      uart_priority,
      timer1_priority,
      ext_irq1_priority,
      timer0_priority,
      ext_irq0_priority
   };

   // a cleared enable silences a source at any level;
   // the global enable gates all of them at once
   assign enable_mask = src_enable_i & {`IPSEL_NSRC{global_enable_i}};
   assign active = src_pending_i & enable_mask;

   // split by level: clear bit low, set bit high
   assign high_req = ipsel_level_req(active, prio_q, LEVEL_HIGH);
   assign low_req = ipsel_level_req(active, prio_q, LEVEL_LOW);

   // request vectors out to the sequencer
   assign high_req_o = high_req;
   assign low_req_o = low_req;

   // level summaries
   assign any_high = ipsel_any(high_req);
   assign any_low = ipsel_any(low_req);

   // high may interrupt low; nothing interrupts high
   assign can_high = !in_high_service_i;

   // low waits while any service routine runs
   assign can_low = !in_high_service_i && !in_low_service_i;

   // request decisions
   assign take_high = can_high && any_high;
   assign take_low = can_low && any_low;

   // high flag tells the sequencer which level it enters;
   // a take with the flag low is a low-level entry
   assign irq_high_o = take_high;
   assign irq_take_o = take_high || take_low;
endmodule // ipsel_top
`default_nettype wire

/* ipsel_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module ipsel_seq(input wire c,r,t,h,output reg lo,hi);
// enters service on each take; a high take leaves low service behind
always @(posedge c) if(!r) {hi,lo}<=2'h0; else if(t) {hi,lo}<={h,!h};
endmodule // ipsel_seq
`default_nettype wire

/* ipsel_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ipsel_sva(input wire sys_clk_i,resetn_i,sfr_wr_i,sfr_hit_o,global_enable_i,
in_high_service_i,irq_high_o,input wire [7:0] sfr_wdata_i,sfr_rdata_o,
input wire [6:0] src_pending_i,src_enable_i,src_priority_o,high_req_o,low_req_o);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!resetn_i);
wire [6:0] act=src_pending_i&src_enable_i&{7{global_enable_i}}; // masked sources
a_rd_unused: assert property(sfr_hit_o|->sfr_rdata_o[7]) else $error("b7");
a_rd_map: assert property(sfr_hit_o|->sfr_rdata_o[6:0]==src_priority_o) else $error("rd");
a_byte_wr: assert property(sfr_hit_o&&sfr_wr_i|=>src_priority_o==$past(sfr_wdata_i[6:0]))
else $error("wr");
a_high_req: assert property(high_req_o==(act&src_priority_o)) else $error("hq");
a_low_req: assert property(low_req_o==(act&~src_priority_o)) else $error("lq");
a_preempt: assert property(irq_high_o==(|high_req_o&&!in_high_service_i)) else $error("hi");
endmodule // ipsel_sva
bind ipsel_top ipsel_sva chk(.*);
`default_nettype wire

/* interrupt_priority_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_select_tb;
logic sys_clk_i=0,resetn_i=0,sfr_wr_i=0,sfr_bit_wr_i=0,sfr_bit_val_i=1,global_enable_i=1;
logic [7:0] sfr_addr_i=8'hB8,sfr_page_i=8'h00,sfr_wdata_i=8'h00;
logic [2:0] sfr_bit_sel_i=3'h2;
logic [6:0] src_pending_i=7'h00,src_enable_i=7'h01;
wire [7:0] sfr_rdata_o;
wire [6:0] src_priority_o,high_req_o,low_req_o;
wire sfr_hit_o,irq_take_o,irq_high_o,in_low_service_i,in_high_service_i;
int error_cnt=0,check_count=0;
ipsel_top uut(.*);
ipsel_seq seq(.c(sys_clk_i),.r(resetn_i),.t(irq_take_o),.h(irq_high_o),
.lo(in_low_service_i),.hi(in_high_service_i));
initial forever #2.5 sys_clk_i=~sys_clk_i;
task ck(logic [7:0] v,e); check_count++; if(v!==e) begin error_cnt++;
$display("BAD %0t %h %h",$time,v,e); end endtask
task wb(logic [7:0] v); @(negedge sys_clk_i) {sfr_wr_i,sfr_wdata_i}={1'b1,v};
@(negedge sys_clk_i) sfr_wr_i=0; endtask
task results; $display("checks %0d errors %0d",check_count,error_cnt);
if(error_cnt==0&&check_count>0) $display("Testbench passed");
else $display("Testbench failed"); $finish; endtask
initial begin
repeat(5) @(negedge sys_clk_i); resetn_i=1;
ck(sfr_rdata_o,8'h80); ck({sfr_hit_o,src_priority_o},8'h80);
$display("test reset done");
for(int i=0;i<7;i++) begin wb(8'h81<<i); ck(sfr_rdata_o,8'h80|8'h01<<i); end
$display("test byte writes done");
sfr_page_i=8'h01; #1 ck({sfr_hit_o,src_priority_o},8'h40); ck(sfr_rdata_o,8'h00);
wb(8'h00); sfr_page_i=8'h00; #1 ck(sfr_rdata_o,8'hC0);
$display("test page decode done");
@(negedge sys_clk_i) sfr_bit_wr_i=1; @(negedge sys_clk_i) sfr_bit_wr_i=0;
ck(sfr_rdata_o,8'hC4); ck({1'b0,src_priority_o},8'h44);
$display("test bit write done");
src_pending_i=7'h7F; @(negedge sys_clk_i); ck({in_low_service_i,low_req_o},8'h81);
src_enable_i=7'h05; #1 ck({irq_high_o,high_req_o},8'h84);
@(negedge sys_clk_i); ck({in_high_service_i,irq_take_o},8'h02);
global_enable_i=0; #1 ck({1'b0,high_req_o|low_req_o},8'h00);
$display("test requests done");
results; end
endmodule // interrupt_priority_select_tb
`default_nettype wire
